//--- rtl/rxpf_filter.sv
// receive pause and mac control frame filter
// How it works
// - per-priority receive enable gates only the user-side pause request and valid outputs, not the quanta
// - transmit pause enable bit gates pause transmission per priority
// - global control frames recognised only while their enable is 1
// - global control address, ethertype, opcode checks each under own enable
// - global control opcode inside min..max range, ethertype equals input
// - unicast destination and source inputs are the reference addresses
// - multicast destination input is the reference for multicast checks
// - priority control recognised only when enabled, each check own enable
// - priority control ethertype match, opcode inside min..max range
// - global pause recognised only when enabled, each check own enable
// - global pause ethertype match, opcode exact match
// - priority pause recognised only when enabled, each check own enable
// - priority pause ethertype match, opcode exact match
// - pause request bit raised on valid pause, held until processed
// - acknowledge bus used only when wait-for-acknowledge is 1
// - control frames forwarded when forward is 1, dropped when 0
// - pause valid bit per priority; standard pause sets bit 8
// - nine quanta outputs, entry 8 holds standard pause quanta
`include "rxpf_map.svh"
module rxpf_filter #(
    parameter int NPRIO = `RXPF_NPRIO,
    parameter int DONE_CYC = `RXPF_DONE_CYC
) (
    input wire logic clock,
    input wire logic rst,
    // received byte stream
    input wire logic rx_valid,
    input wire logic rx_sop,
    input wire logic rx_eop,
    input wire logic rx_err,
    input wire logic [7:0] rx_data,
    // forwarded stream to the user
    output logic fwd_valid,
    output logic fwd_sop,
    output logic fwd_eop,
    output logic fwd_err,
    output logic [7:0] fwd_data,
    // enables
    input wire logic [NPRIO-1:0] rx_pause_enable,
    input wire logic [NPRIO-1:0] tx_pause_enable,
    input wire logic [NPRIO-1:0] tx_pause_req,
    output logic [NPRIO-1:0] tx_pause_send,
    input wire logic [47:0] xoff_unicast_dest,
    input wire logic [47:0] xoff_source_addr,
    input wire logic [47:0] xoff_multicast_dest,
    // global control
    input wire logic glob_ctrl_en,
    input wire logic glob_ctrl_mcast_chk,
    input wire logic glob_ctrl_ucast_chk,
    input wire logic glob_ctrl_src_chk,
    input wire logic glob_ctrl_etype_chk,
    input wire logic glob_ctrl_op_chk,
    input wire logic [15:0] glob_ctrl_op_min,
    input wire logic [15:0] glob_ctrl_op_max,
    input wire logic [15:0] glob_ctrl_etype,
    // priority control
    input wire logic prio_ctrl_en,
    input wire logic prio_ctrl_mcast_chk,
    input wire logic prio_ctrl_ucast_chk,
    input wire logic prio_ctrl_src_chk,
    input wire logic prio_ctrl_etype_chk,
    input wire logic prio_ctrl_op_chk,
    input wire logic [15:0] prio_ctrl_op_min,
    input wire logic [15:0] prio_ctrl_op_max,
    input wire logic [15:0] prio_ctrl_etype,
    // global pause
    input wire logic glob_xoff_en,
    input wire logic glob_xoff_mcast_chk,
    input wire logic glob_xoff_ucast_chk,
    input wire logic glob_xoff_src_chk,
    input wire logic glob_xoff_etype_chk,
    input wire logic glob_xoff_op_chk,
    input wire logic [15:0] glob_xoff_etype,
    input wire logic [15:0] glob_xoff_opcode,
    // priority pause
    input wire logic prio_xoff_en,
    input wire logic prio_xoff_mcast_chk,
    input wire logic prio_xoff_ucast_chk,
    input wire logic prio_xoff_src_chk,
    input wire logic prio_xoff_etype_chk,
    input wire logic prio_xoff_op_chk,
    input wire logic [15:0] prio_xoff_etype,
    input wire logic [15:0] prio_xoff_opcode,
    // user pause handshake
    output logic [NPRIO-1:0] pause_req,
    input wire logic [NPRIO-1:0] pause_ack,
    input wire logic wait_ack,
    input wire logic forward_ctrl,
    output logic [NPRIO-1:0] pause_valid,
    output logic [NPRIO*16-1:0] pause_quanta
);
    localparam int GB = `RXPF_GLOBAL_BIT;
    localparam int HB = `RXPF_HDR_BYTES;

    rxpf_pkg::rxpf_state_t state_q;
    logic [7:0] hdr_q [HB];
    logic [4:0] cnt_q;
    logic [47:0] dest_w;
    logic [47:0] src_w;
    logic [15:0] etype_w;
    logic [15:0] op_w;
    logic [15:0] cev_w;
    logic hit_gc;
    logic hit_pc;
    logic hit_gp;
    logic hit_pp;
    logic is_ctrl;
    logic frame_end;
    logic frame_ok;
    logic [NPRIO-1:0] new_pause;
    logic [NPRIO-1:0] busy_q;
    logic [NPRIO-1:0] done_tick;
    logic [7:0] done_cnt_q [NPRIO];
    logic [NPRIO*16-1:0] quanta_q;
    logic [NPRIO-1:0] req_q;
    logic [NPRIO-1:0] valid_q;
    logic [7:0] hold_data [HB];
    logic drop_q;
    logic out_drop_q;
    logic drop_w;

    function automatic logic [15:0] hdr16(input int idx);
        hdr16 = {hdr_q[idx], hdr_q[idx+1]};
    endfunction

    assign dest_w = {hdr_q[0], hdr_q[1], hdr_q[2], hdr_q[3], hdr_q[4], hdr_q[5]};
    assign src_w = {hdr_q[6], hdr_q[7], hdr_q[8], hdr_q[9], hdr_q[10], hdr_q[11]};
    // a continuous assignment would not follow hdr_q read inside the function
    always_comb
    begin
        etype_w = hdr16(12);
        op_w = hdr16(14);
        cev_w = hdr16(16);
    end

    rxpf_class_match #(.RANGE_OP(1'b1)) u_gc (
        .en(glob_ctrl_en),
        .chk_mcast(glob_ctrl_mcast_chk),
        .chk_ucast(glob_ctrl_ucast_chk),
        .chk_src(glob_ctrl_src_chk),
        .chk_etype(glob_ctrl_etype_chk),
        .chk_opcode(glob_ctrl_op_chk),
        .dest(dest_w),
        .src(src_w),
        .etype(etype_w),
        .opcode(op_w),
        .mcast_addr(xoff_multicast_dest),
        .ucast_addr(xoff_unicast_dest),
        .src_addr(xoff_source_addr),
        .etype_ref(glob_ctrl_etype),
        .op_lo(glob_ctrl_op_min),
        .op_hi(glob_ctrl_op_max),
        .hit(hit_gc)
    );
    rxpf_class_match #(.RANGE_OP(1'b1)) u_pc (
        .en(prio_ctrl_en),
        .chk_mcast(prio_ctrl_mcast_chk),
        .chk_ucast(prio_ctrl_ucast_chk),
        .chk_src(prio_ctrl_src_chk),
        .chk_etype(prio_ctrl_etype_chk),
        .chk_opcode(prio_ctrl_op_chk),
        .dest(dest_w),
        .src(src_w),
        .etype(etype_w),
        .opcode(op_w),
        .mcast_addr(xoff_multicast_dest),
        .ucast_addr(xoff_unicast_dest),
        .src_addr(xoff_source_addr),
        .etype_ref(prio_ctrl_etype),
        .op_lo(prio_ctrl_op_min),
        .op_hi(prio_ctrl_op_max),
        .hit(hit_pc)
    );
    rxpf_class_match #(.RANGE_OP(1'b0)) u_gp (
        .en(glob_xoff_en),
        .chk_mcast(glob_xoff_mcast_chk),
        .chk_ucast(glob_xoff_ucast_chk),
        .chk_src(glob_xoff_src_chk),
        .chk_etype(glob_xoff_etype_chk),
        .chk_opcode(glob_xoff_op_chk),
        .dest(dest_w),
        .src(src_w),
        .etype(etype_w),
        .opcode(op_w),
        .mcast_addr(xoff_multicast_dest),
        .ucast_addr(xoff_unicast_dest),
        .src_addr(xoff_source_addr),
        .etype_ref(glob_xoff_etype),
        .op_lo(glob_xoff_opcode),
        .op_hi(glob_xoff_opcode),
        .hit(hit_gp)
    );
    rxpf_class_match #(.RANGE_OP(1'b0)) u_pp (
        .en(prio_xoff_en),
        .chk_mcast(prio_xoff_mcast_chk),
        .chk_ucast(prio_xoff_ucast_chk),
        .chk_src(prio_xoff_src_chk),
        .chk_etype(prio_xoff_etype_chk),
        .chk_opcode(prio_xoff_op_chk),
        .dest(dest_w),
        .src(src_w),
        .etype(etype_w),
        .opcode(op_w),
        .mcast_addr(xoff_multicast_dest),
        .ucast_addr(xoff_unicast_dest),
        .src_addr(xoff_source_addr),
        .etype_ref(prio_xoff_etype),
        .op_lo(prio_xoff_opcode),
        .op_hi(prio_xoff_opcode),
        .hit(hit_pp)
    );

    assign is_ctrl = hit_gc || hit_pc || hit_gp || hit_pp;
    assign frame_end = rx_valid && rx_eop && state_q != rxpf_pkg::RXPF_IDLE;
    // pause acts only on frames that end cleanly and carry the full header;
    // the last header byte may itself carry eop, when the count is one short
    assign frame_ok = frame_end && !rx_err && cnt_q >= 5'(HB - 1);

    // a priority pause carries a class-enable vector; global pause uses bit 8
    always_comb
    begin
        new_pause = '0;
        if (frame_ok && hit_pp)
            new_pause[GB-1:0] = cev_w[GB-1:0];
        if (frame_ok && hit_gp)
            new_pause[GB] = 1'b1;
    end

    // header capture; later bytes are neither counted nor stored
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state_q <= rxpf_pkg::RXPF_IDLE;
            cnt_q <= '0;
        end
        else if (rx_valid)
        begin
            case (state_q)
                rxpf_pkg::RXPF_IDLE:
                    if (rx_sop && !rx_eop)
                    begin
                        state_q <= rxpf_pkg::RXPF_HDR;
                        cnt_q <= 5'd1;
                    end
                rxpf_pkg::RXPF_HDR:
                    if (rx_eop)
                        state_q <= rxpf_pkg::RXPF_IDLE;
                    else
                    begin
                        cnt_q <= cnt_q + 5'd1;
                        if (cnt_q == 5'(HB - 1))
                            state_q <= rxpf_pkg::RXPF_BODY;
                    end
                rxpf_pkg::RXPF_BODY:
                    if (rx_eop)
                        state_q <= rxpf_pkg::RXPF_IDLE;
                default:
                    state_q <= rxpf_pkg::RXPF_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (rx_valid && (rx_sop || (state_q == rxpf_pkg::RXPF_HDR && cnt_q < 5'(HB))))
            hdr_q[rx_sop ? 0 : cnt_q] <= rx_data;
    end

    // the header is delayed so a control frame can be dropped whole
    always_ff @(posedge clock)
    begin
        hold_data[0] <= rx_data;
        for (int i = 1; i < HB; i++)
            hold_data[i] <= hold_data[i-1];
    end

    // forward path: bytes leave once classification is known at header end;
    // latency is the header length plus the output register, which keeps the decision simple
    logic [HB-1:0] v_sr;
    logic [HB-1:0] s_sr;
    logic [HB-1:0] e_sr;
    logic [HB-1:0] r_sr;
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            v_sr <= '0;
            s_sr <= '0;
            e_sr <= '0;
            r_sr <= '0;
        end
        else
        begin
            v_sr <= {v_sr[HB-2:0], rx_valid};
            s_sr <= {s_sr[HB-2:0], rx_sop};
            e_sr <= {e_sr[HB-2:0], rx_eop};
            r_sr <= {r_sr[HB-2:0], rx_err};
        end
    end

    // drop decision is taken once the header is complete
    always_ff @(posedge clock)
    begin
        if (rst)
            drop_q <= 1'b0;
        else if (rx_valid && state_q == rxpf_pkg::RXPF_HDR && cnt_q == 5'(HB - 1))
            drop_q <= is_ctrl && !forward_ctrl;
        else if (rx_valid && rx_sop)
            drop_q <= 1'b0;
    end

    // the decision travels with the frame to the output, so the next sop
    // cannot reopen a dropped frame whose tail is still draining;
    // limitation: header bytes must arrive without gaps
    assign drop_w = (v_sr[HB-1] && s_sr[HB-1]) ? drop_q : out_drop_q;
    always_ff @(posedge clock)
    begin
        if (rst)
            out_drop_q <= 1'b0;
        else if (v_sr[HB-1] && s_sr[HB-1])
            out_drop_q <= drop_q;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            fwd_valid <= 1'b0;
            fwd_sop <= 1'b0;
            fwd_eop <= 1'b0;
            fwd_err <= 1'b0;
            fwd_data <= '0;
        end
        else
        begin
            fwd_valid <= v_sr[HB-1] && !drop_w;
            fwd_sop <= s_sr[HB-1];
            fwd_eop <= e_sr[HB-1];
            fwd_err <= r_sr[HB-1];
            fwd_data <= hold_data[HB-1];
        end
    end

    // quanta capture; of a priority pause only the first quanta after the vector is kept, in entry 0
    always_ff @(posedge clock)
    begin
        if (rst)
            quanta_q <= '0;
        else
        begin
            if (frame_ok && hit_gp)
                quanta_q[GB*16 +: 16] <= cev_w;
            if (frame_ok && hit_pp)
                quanta_q[0 +: 16] <= hdr16(18);
        end
    end

    // internal processing timer per priority
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            busy_q <= '0;
            for (int p = 0; p < NPRIO; p++)
                done_cnt_q[p] <= '0;
        end
        else
            for (int p = 0; p < NPRIO; p++)
                if (new_pause[p])
                begin
                    busy_q[p] <= 1'b1;
                    done_cnt_q[p] <= 8'(DONE_CYC);
                end
                else if (busy_q[p])
                begin
                    done_cnt_q[p] <= done_cnt_q[p] - 8'd1;
                    if (done_cnt_q[p] == 8'd1)
                        busy_q[p] <= 1'b0;
                end
    end
    assign done_tick = busy_q & ~new_pause;

    // request and valid; a new pause in the clear cycle wins
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            req_q <= '0;
            valid_q <= '0;
        end
        else
            for (int p = 0; p < NPRIO; p++)
            begin
                if (new_pause[p])
                    req_q[p] <= 1'b1;
                else if (wait_ack ? pause_ack[p] : (done_tick[p] && done_cnt_q[p] == 8'd1))
                    req_q[p] <= 1'b0;
                valid_q[p] <= new_pause[p];
            end
    end

    assign pause_req = req_q & rx_pause_enable;
    assign pause_valid = valid_q & rx_pause_enable;
    assign pause_quanta = quanta_q;
    assign tx_pause_send = tx_pause_req & tx_pause_enable;

    a_req_on_pause: assert property (@(posedge clock) disable iff (rst)
        new_pause[GB] |=> req_q[GB])
        else $error("request not raised after global pause");
    a_ack_clears: assert property (@(posedge clock) disable iff (rst)
        wait_ack && pause_ack[0] && !new_pause[0] |=> !req_q[0])
        else $error("acknowledge did not clear request");
    a_hold_no_ack: assert property (@(posedge clock) disable iff (rst)
        wait_ack && req_q[0] && !pause_ack[0] |=> req_q[0])
        else $error("request dropped without acknowledge");
    a_valid_pulse: assert property (@(posedge clock) disable iff (rst)
        valid_q[GB] |-> $past(new_pause[GB]))
        else $error("valid without pause");
    a_rx_gate: assert property (@(posedge clock) disable iff (rst)
        !rx_pause_enable[0] |-> !pause_req[0] && !pause_valid[0])
        else $error("disabled priority reported");
    a_tx_gate: assert property (@(posedge clock) disable iff (rst)
        !tx_pause_enable[GB] |-> !tx_pause_send[GB])
        else $error("pause sent while disabled");
    a_gp_enable: assert property (@(posedge clock) disable iff (rst)
        !glob_xoff_en |=> !valid_q[GB])
        else $error("global pause valid while disabled");
    a_drop_ctrl: assert property (@(posedge clock) disable iff (rst)
        rx_valid && state_q == rxpf_pkg::RXPF_HDR && cnt_q == 5'(HB - 1)
        && is_ctrl && !forward_ctrl |-> ##2 !fwd_valid)
        else $error("dropped frame forwarded");
endmodule

//--- rtl/rxpf_map.svh
// constants for the receive pause frame filter
`ifndef RXPF_MAP_SVH
`define RXPF_MAP_SVH
`define RXPF_NPRIO 9
`define RXPF_GLOBAL_BIT 8
`define RXPF_QUANTA_W 16
`define RXPF_ADDR_W 48
`define RXPF_HDR_BYTES 22
`define RXPF_DONE_NS 100
`define RXPF_CLK_NS 10
`define RXPF_DONE_CYC ((`RXPF_DONE_NS + `RXPF_CLK_NS - 1) / `RXPF_CLK_NS)
`endif

//--- rtl/rxpf_pkg.sv
// types shared by the receive pause frame filter
package rxpf_pkg;
    typedef enum logic [1:0]
    {
        RXPF_IDLE = 2'b00,
        RXPF_HDR = 2'b01,
        RXPF_BODY = 2'b11,
        RXPF_DONE = 2'b10
    } rxpf_state_t;

    typedef struct packed
    {
        logic en;
        logic chk_mcast;
        logic chk_ucast;
        logic chk_src;
        logic chk_etype;
        logic chk_opcode;
    } rxpf_class_cfg_t;
endpackage

//--- rtl/rxpf_class_match.sv
// header checks for one class of control frame
module rxpf_class_match #(
    parameter bit RANGE_OP = 1'b0
) (
    input wire logic en,
    input wire logic chk_mcast,
    input wire logic chk_ucast,
    input wire logic chk_src,
    input wire logic chk_etype,
    input wire logic chk_opcode,
    input wire logic [47:0] dest,
    input wire logic [47:0] src,
    input wire logic [15:0] etype,
    input wire logic [15:0] opcode,
    input wire logic [47:0] mcast_addr,
    input wire logic [47:0] ucast_addr,
    input wire logic [47:0] src_addr,
    input wire logic [15:0] etype_ref,
    input wire logic [15:0] op_lo,
    input wire logic [15:0] op_hi,
    output logic hit
);
    logic op_ok;
    logic da_ok;

    // exact opcode for pause classes, inclusive range for control classes
    assign op_ok = RANGE_OP ? (opcode >= op_lo && opcode <= op_hi) : (opcode == op_lo);
    // with both destination checks on, either address is accepted
    always_comb
    begin
        if (chk_mcast && chk_ucast)
            da_ok = (dest == mcast_addr) || (dest == ucast_addr);
        else if (chk_mcast)
            da_ok = dest == mcast_addr;
        else if (chk_ucast)
            da_ok = dest == ucast_addr;
        else
            da_ok = 1'b1;
    end
    assign hit = en
        && da_ok
        && (!chk_src || src == src_addr)
        && (!chk_etype || etype == etype_ref)
        && (!chk_opcode || op_ok);
endmodule

//--- test/rxpf_user_model.sv
// user logic model that acknowledges pause requests after a set delay
module rxpf_user_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic [8:0] pause_req,
    input wire logic [7:0] ack_delay,
    output logic [8:0] pause_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] wait_q [9];
    // ack is dropped as soon as the request falls, never held over
    always_ff @(posedge clock)
    begin
        for (int i = 0; i < 9; i++)
        begin
            if (rst || !pause_req[i])
            begin
                wait_q[i] <= 8'h00;
                pause_ack[i] <= 1'b0;
            end
            else if (wait_q[i] >= ack_delay)
                pause_ack[i] <= 1'b1;
            else
                wait_q[i] <= wait_q[i] + 8'h01;
        end
    end
endmodule

//--- test/rx_pause_frame_filter_bench.sv
// self-checking bench for the receive pause frame filter
module rx_pause_frame_filter_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst, rx_valid, rx_sop, rx_eop, rx_err, fwd_valid, fwd_eop, fwd_sop, fwd_err;
    logic eop_err;
    logic wait_ack, forward_ctrl;
    logic [7:0] rx_data, ack_delay, fwd_data, first_b;
    logic [8:0] rx_pause_enable, tx_pause_enable, tx_pause_req, tx_pause_send;
    logic [8:0] pause_req, pause_ack, pause_valid, acc_valid, acc_req;
    logic [47:0] ucast, src, mcast;
    logic [5:0] gc_c, pc_c, gx_c, px_c;
    logic [15:0] etype, gc_min, gc_max, pc_min, pc_max, gx_op, px_op, q8s, q0s, v, q;
    logic [143:0] pause_quanta;
    logic [5:0] masks [4];
    int fwd_cnt, err_total, num_checks, cnt;

    rxpf_filter dut (.clock(clock), .rst(rst), .rx_valid(rx_valid), .rx_sop(rx_sop),
        .rx_eop(rx_eop), .rx_err(rx_err), .rx_data(rx_data), .fwd_valid(fwd_valid),
        .fwd_sop(fwd_sop), .fwd_eop(fwd_eop), .fwd_err(fwd_err), .fwd_data(fwd_data),
        .rx_pause_enable(rx_pause_enable), .tx_pause_enable(tx_pause_enable),
        .tx_pause_req(tx_pause_req), .tx_pause_send(tx_pause_send),
        .xoff_unicast_dest(ucast), .xoff_source_addr(src), .xoff_multicast_dest(mcast),
        .glob_ctrl_en(gc_c[5]), .glob_ctrl_mcast_chk(gc_c[4]), .glob_ctrl_ucast_chk(gc_c[3]),
        .glob_ctrl_src_chk(gc_c[2]), .glob_ctrl_etype_chk(gc_c[1]),
        .glob_ctrl_op_chk(gc_c[0]), .glob_ctrl_op_min(gc_min), .glob_ctrl_op_max(gc_max),
        .glob_ctrl_etype(etype), .prio_ctrl_en(pc_c[5]), .prio_ctrl_mcast_chk(pc_c[4]),
        .prio_ctrl_ucast_chk(pc_c[3]), .prio_ctrl_src_chk(pc_c[2]),
        .prio_ctrl_etype_chk(pc_c[1]), .prio_ctrl_op_chk(pc_c[0]),
        .prio_ctrl_op_min(pc_min), .prio_ctrl_op_max(pc_max), .prio_ctrl_etype(etype),
        .glob_xoff_en(gx_c[5]), .glob_xoff_mcast_chk(gx_c[4]), .glob_xoff_ucast_chk(gx_c[3]),
        .glob_xoff_src_chk(gx_c[2]), .glob_xoff_etype_chk(gx_c[1]),
        .glob_xoff_op_chk(gx_c[0]), .glob_xoff_etype(etype), .glob_xoff_opcode(gx_op),
        .prio_xoff_en(px_c[5]), .prio_xoff_mcast_chk(px_c[4]), .prio_xoff_ucast_chk(px_c[3]),
        .prio_xoff_src_chk(px_c[2]), .prio_xoff_etype_chk(px_c[1]),
        .prio_xoff_op_chk(px_c[0]), .prio_xoff_etype(etype), .prio_xoff_opcode(px_op),
        .pause_req(pause_req), .pause_ack(pause_ack), .wait_ack(wait_ack),
        .forward_ctrl(forward_ctrl), .pause_valid(pause_valid), .pause_quanta(pause_quanta));

    rxpf_user_model user (.clock(clock), .rst(rst), .pause_req(pause_req),
        .ack_delay(ack_delay), .pause_ack(pause_ack));

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // pulses are collected so the check does not hinge on the exact edge
    always @(posedge clock)
    begin
        acc_valid <= acc_valid | pause_valid;
        acc_req <= acc_req | pause_req;
        if (pause_valid[8])
            q8s <= pause_quanta[143:128];
        if (pause_valid[0])
            q0s <= pause_quanta[15:0];
        if (fwd_valid && fwd_sop)
            first_b <= fwd_data;
        if (fwd_valid && fwd_eop)
        begin
            fwd_cnt <= fwd_cnt + 1;
            eop_err <= fwd_err;
        end
    end

    task automatic chk(input logic [15:0] seen, exp, input string msg);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic frame(input logic [47:0] da, sa, input logic [15:0] et, op, fv, fq,
                         input logic err, input int len, input logic [8:0] exp);
        logic [175:0] hdr;
        hdr = {da, sa, et, op, fv, fq, 16'h0000};
        acc_valid = 9'h000;
        acc_req = 9'h000;
        for (int i = 0; i < len; i++)
        begin
            @(negedge clock);
            rx_valid = 1'b1;
            rx_sop = (i == 0);
            rx_eop = (i == len - 1);
            rx_err = err && (i == len - 1);
            rx_data = (i < 22) ? hdr[175 - 8 * i -: 8] : 8'($urandom);
        end
        @(negedge clock);
        rx_valid = 1'b0;
        rx_sop = 1'b0;
        rx_eop = 1'b0;
        rx_err = 1'b0;
        repeat (2) @(negedge clock);
        chk(16'(acc_valid), 16'(exp), "pause valid");
        chk(16'(acc_req), 16'(exp), "pause request");
        if (exp[8])
            chk(q8s, fv, "global quanta");
        else if (exp[0])
            chk(q0s, fq, "priority quanta");
    endtask

    task automatic drain(output int n);
        n = 0;
        // let a changed enable reach pause_req before it is tested
        @(negedge clock);
        while (pause_req !== 9'h000)
        begin
            @(negedge clock);
            n++;
            if (n > 300)
            begin
                chk(16'h0001, 16'h0000, "request stuck");
                end_of_test;
            end
        end
    endtask

    task automatic fwd(input logic [15:0] op, input logic [15:0] exp);
        int n0;
        n0 = fwd_cnt;
        frame(mcast, src, etype, op, 16'h0000, 16'h0000, 1'b0, 22, 9'h000);
        repeat (30) @(negedge clock);
        chk(16'(fwd_cnt - n0), exp, "forwarded frames");
        if (exp != 16'h0000)
        begin
            chk(16'(first_b), 16'(mcast[47:40]), "forwarded first byte");
            chk(16'(eop_err), 16'h0000, "forwarded error flag");
        end
    endtask

    initial
    begin
        void'($urandom(85));
        {rst, rx_valid, rx_sop, rx_eop, rx_err, rx_data} = {1'b1, 12'h000};
        {tx_pause_enable, tx_pause_req, rx_pause_enable} = {18'h00000, 9'h1FF};
        {gc_c, pc_c, gx_c, px_c} = {4{6'h3F}};
        {wait_ack, forward_ctrl, ack_delay, fwd_cnt} = {2'b10, 8'h02, 32'h0};
        ucast = {16'($urandom), 32'($urandom)};
        src = {16'($urandom), 32'($urandom)};
        mcast = {8'h01, 40'($urandom)};
        {etype, gx_op, px_op} = {16'h8808, 16'h0001, 16'h0101};
        {gc_min, gc_max, pc_min, pc_max} = {16'h0200, 16'h02FF, 16'h0301, 16'h03FF};
        masks = '{6'h18, 6'h04, 6'h02, 6'h01};
        repeat (20) @(negedge clock);
        rst = 1'b0;
        for (int n = 0; n < 10; n++)
        begin
            {rx_pause_enable, v, q} = {9'($urandom), 16'($urandom), 16'($urandom)};
            ack_delay = 8'($urandom_range(1, 8));
            if (n[0])
                frame(mcast, src, etype, px_op, v, q, 1'b0, 22 + $urandom_range(0, 9),
                      {1'b0, v[7:0]} & rx_pause_enable);
            else
                frame(ucast, src, etype, gx_op, v, q, 1'b0, 22,
                      9'h100 & rx_pause_enable);
            // requests hidden by the random enable still wait for an ack
            rx_pause_enable = 9'h1FF;
            drain(cnt);
        end
        // a corrupted field is refused only while its check is switched on
        for (int k = 0; k < 4; k++)
            for (int on = 1; on >= 0; on--)
            begin
                gx_c = (on != 0) ? 6'h3F : 6'h3F & ~masks[k];
                frame((k == 0) ? ~mcast : mcast, (k == 1) ? ~src : src,
                      (k == 2) ? ~etype : etype, (k == 3) ? ~gx_op : gx_op, v, q, 1'b0, 22,
                      (on != 0) ? 9'h000 : 9'h100);
                drain(cnt);
            end
        gx_c = 6'h1F;
        frame(mcast, src, etype, gx_op, v, q, 1'b0, 22, 9'h000);
        {gx_c, px_c} = {6'h3F, 6'h1F};
        frame(mcast, src, etype, px_op, 16'h00FF, q, 1'b0, 22, 9'h000);
        px_c = 6'h3F;
        frame(mcast, src, etype, gx_op, v, q, 1'b1, 22, 9'h000);
        frame(mcast, src, etype, gx_op, v, q, 1'b0, 21, 9'h000);
        ack_delay = 8'h28;
        frame(mcast, src, etype, gx_op, v, q, 1'b0, 22, 9'h100);
        drain(cnt);
        chk(16'(cnt >= 35), 16'h0001, "request held for ack");
        // an early ack must not cut the processing time short
        {wait_ack, ack_delay} = {1'b0, 8'h01};
        frame(mcast, src, etype, gx_op, v, q, 1'b0, 22, 9'h100);
        drain(cnt);
        chk(16'(cnt >= 4 && cnt <= 10), 16'h0001, "request without ack");
        repeat (30) @(negedge clock);
        fwd(gc_min, 16'h0000);
        fwd(gc_max, 16'h0000);
        fwd(gc_max + 16'h0001, 16'h0001);
        fwd(pc_min, 16'h0000);
        fwd(pc_max, 16'h0000);
        gc_c = 6'h1F;
        fwd(gc_min, 16'h0001);
        {gc_c, forward_ctrl} = {6'h3F, 1'b1};
        fwd(gc_min, 16'h0001);
        for (int n = 0; n < 16; n++)
        begin
            @(negedge clock);
            {tx_pause_enable, tx_pause_req} = {9'($urandom), 9'($urandom)};
            #1;
            chk(16'(tx_pause_send), 16'(tx_pause_req & tx_pause_enable), "tx send");
        end
        end_of_test;
    end
endmodule
